// ===== flash_otp_pkg.sv
// Shared constants for the reset and secured-OTP command block.
// Assumes a 100 MHz core clock; opcodes arrive MSB first, one per frame.
`default_nettype none
package flash_otp_pkg;

   // ==========================================================
   // Instruction codes
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_OTP_MODE_ENTRY = 8'hB1;
   localparam logic [7:0] OP_OTP_MODE_EXIT = 8'hC1;
   localparam logic [7:0] OP_LOCK_RD = 8'h2B;
   localparam logic [7:0] OP_LOCK_WR = 8'h2F;
   localparam logic [7:0] OP_STAT_WR1 = 8'h01;
   localparam logic [7:0] OP_STAT_WR2 = 8'h31;

   // ==========================================================
   // Lock-status register layout
   localparam int LOCK_FACTORY_BIT = 0;
   localparam int LOCK_CUSTOMER_BIT = 1;
   localparam logic [5:0] LOCK_RSVD_VALUE = 6'h00;

   // ==========================================================
   // Secured region map
   localparam logic [23:0] OTP_SERIAL_LAST = 24'h00000F;
   localparam logic [23:0] OTP_LAST = 24'h0001FF;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_RST_NS = 30000;
   localparam int RST_CYCLES = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Reset sequencing states
   typedef enum logic [2:0] {
      ST_NORMAL = 3'b001,
      ST_ARMED = 3'b010,
      ST_RESETTING = 3'b100
   } rst_state_t;

   // Opcodes consumed here and not passed on
   function automatic logic is_local_op(input logic [7:0] op);
      is_local_op = (op == OP_RST_EN) || (op == OP_RST) || (op == OP_OTP_MODE_ENTRY)
         || (op == OP_OTP_MODE_EXIT) || (op == OP_LOCK_RD) || (op == OP_LOCK_WR);
   endfunction : is_local_op

endpackage : flash_otp_pkg
`default_nettype wire

// ===== spi_link_if.sv
// Carrier between the serial-clock shifter and the core-clock logic.
// Every signal here crosses clock domains; rx_byte is qualified by rx_toggle, the rest are synchronised by their reader.
`timescale 1ns/1ns
`default_nettype none
interface spi_link_if;
   logic [7:0] rx_byte;
   logic rx_toggle;
   logic partial;
   logic [1:0] lock_bits;
   logic busy;
   modport link (output rx_byte, output rx_toggle, output partial,
      input lock_bits, input busy);
   modport core (input rx_byte, input rx_toggle, input partial,
      output lock_bits, output busy);
endinterface : spi_link_if
`default_nettype wire

// ===== spi_link_shifter.sv
// Serial-clock side: shifts in bytes, answers the lock-status read.
// Assumes chip select idles high so the frame flags start cleared.
`timescale 1ns/1ns
`default_nettype none
module spi_link_shifter (
   input wire logic i_rst_n,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe,
   spi_link_if.link lnk
);
   logic seen;
   logic first_done;
   logic rd_act;
   logic [2:0] bit_cnt;
   logic [6:0] shreg;
   logic [2:0] out_idx;
   logic [2:0] st_s1;
   logic [2:0] st_s2;

   // ==========================================================
   // Bit counting; a stale count is never used before the first edge
   wire logic [2:0] next_cnt = seen ? bit_cnt + 3'h1 : 3'h1;
   wire logic byte_done = (next_cnt == 3'h0);
   wire logic [7:0] next_byte = {shreg, i_mosi};
   wire logic [7:0] stat_byte = {flash_otp_pkg::LOCK_RSVD_VALUE, st_s2[1:0]};
   assign lnk.partial = |bit_cnt;

   // Frame flags cleared by chip select itself, since the clock stops
   always_ff @(posedge i_sclk or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         seen <= 1'b0;
         first_done <= 1'b0;
         rd_act <= 1'b0;
      end
      else
      begin
         seen <= 1'b1;
         if (byte_done)
         begin
            first_done <= 1'b1;
            if (!first_done && next_byte == flash_otp_pkg::OP_LOCK_RD && !st_s2[2])
               rd_act <= 1'b1;
         end
      end
   end

   // Shift register, byte hand-off toggle, status synchroniser
   always_ff @(posedge i_sclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         bit_cnt <= 3'h0;
         shreg <= 7'h00;
         lnk.rx_byte <= 8'h00;
         lnk.rx_toggle <= 1'b0;
         st_s1 <= 3'h0;
         st_s2 <= 3'h0;
      end
      else
      begin
         bit_cnt <= next_cnt;
         shreg <= next_byte[6:0];
         st_s1 <= {lnk.busy, lnk.lock_bits};
         st_s2 <= st_s1;
         if (byte_done)
         begin
            lnk.rx_byte <= next_byte;
            lnk.rx_toggle <= ~lnk.rx_toggle;
         end
      end
   end

   // Status byte repeats for as long as the host keeps clocking
   always_ff @(negedge i_sclk or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         o_miso_oe <= 1'b0;
         o_miso <= 1'b0;
         out_idx <= 3'h0;
      end
      else if (rd_act)
      begin
         o_miso_oe <= 1'b1;
         o_miso <= stat_byte[3'h7 - out_idx];
         out_idx <= out_idx + 3'h1;
      end
   end

   // ==========================================================
   // Checks
   property p_oe_only_on_read;
      @(negedge i_sclk) disable iff (i_cs_n) o_miso_oe |-> rd_act;
   endproperty
   a_oe_only_on_read: assert property (p_oe_only_on_read) else $error("miso driven");
endmodule : spi_link_shifter
`default_nettype wire

// ===== reset_timer.sv
// Counts out the software reset recovery interval on the core clock.
// Assumes a one-cycle start pulse; a new start reloads the count.
`timescale 1ns/1ns
`default_nettype none
module reset_timer #(
   parameter int CYCLES = flash_otp_pkg::RST_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_start,
   output logic o_busy
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt;

   // ==========================================================
   // Down counter, busy is high for exactly CYCLES cycles
   wire logic [W-1:0] next_cnt = i_start ? W'(CYCLES)
      : ((cnt != '0) ? cnt - W'(1) : '0);

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt <= '0;
         o_busy <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         o_busy <= (next_cnt != '0);
      end
   end

   // ==========================================================
   // Checks
   property p_start_loads;
      @(posedge i_mclk) disable iff (!i_rst_n) i_start |=> o_busy && cnt == W'(CYCLES);
   endproperty
   a_start_loads: assert property (p_start_loads) else $error("timer not loaded");
   property p_busy_ends_at_zero;
      @(posedge i_mclk) disable iff (!i_rst_n) $fell(o_busy) |-> $past(cnt) == W'(1);
   endproperty
   a_busy_ends_at_zero: assert property (p_busy_ends_at_zero) else $error("early end");
endmodule : reset_timer
`default_nettype wire

// ===== flash_reset_otp.sv
// Reset sequencing and secured-OTP control for a serial flash front end.
// Assumes the host owns sclk and chip select; other opcodes go onward outside the reset interval, status writes only outside secured mode.
`timescale 1ns/1ns
`default_nettype none
module flash_reset_otp #(
   parameter int RST_CYCLES = flash_otp_pkg::RST_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe,
   input wire logic i_factory_lock,
   input wire logic i_cust_lock_nv,
   input wire logic i_array_busy,
   input wire logic [23:0] i_access_addr,
   output logic o_addr_in_otp,
   output logic o_addr_is_serial,
   output logic o_otp_mode,
   output logic o_reset_abort,
   output logic o_reset_busy,
   output logic o_busy,
   output logic o_cust_lock_prog,
   output logic o_otp_write_allow,
   output logic o_array_write_allow,
   output logic o_status_write_allow,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_opcode
);
   // ==========================================================
   // Serial side
   spi_link_if lnk ();

   spi_link_shifter u_shifter (
      .i_rst_n(i_rst_n),
      .i_sclk(i_sclk),
      .i_cs_n(i_cs_n),
      .i_mosi(i_mosi),
      .o_miso(o_miso),
      .o_miso_oe(o_miso_oe),
      .lnk(lnk.link)
   );

   // ==========================================================
   // Crossings into the core clock
   logic cs_s1;
   logic cs_s2;
   logic cs_d;
   logic tg_s1;
   logic tg_s2;
   logic tg_d;
   logic pt_s1;
   logic pt_s2;

   // Two flops per level; only the second stage and later are read
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_d <= 1'b1;
         tg_s1 <= 1'b0;
         tg_s2 <= 1'b0;
         tg_d <= 1'b0;
         pt_s1 <= 1'b0;
         pt_s2 <= 1'b0;
      end
      else
      begin
         cs_s1 <= i_cs_n;
         cs_s2 <= cs_s1;
         cs_d <= cs_s2;
         tg_s1 <= lnk.rx_toggle;
         tg_s2 <= tg_s1;
         tg_d <= tg_s2;
         pt_s1 <= lnk.partial;
         pt_s2 <= pt_s1;
      end
   end

   // ==========================================================
   // Frame tracking
   logic [1:0] byte_cnt;
   logic [7:0] opcode;
   logic [7:0] data;
   logic rst_busy;
   logic otp_mode;
   logic fact_lock;
   logic cust_lock;
   logic locks_loaded;
   flash_otp_pkg::rst_state_t state;
   flash_otp_pkg::rst_state_t next_state;

   // Byte data is stable for a whole byte time, so the toggle qualifies it
   wire logic byte_ev = tg_s2 ^ tg_d;
   wire logic frame_end = cs_s2 & ~cs_d;
   wire logic locked = fact_lock | cust_lock;
   wire logic aligned = ~pt_s2;
   // Nothing is executed while the reset interval runs
   wire logic exec = frame_end & (byte_cnt != 2'h0) & ~rst_busy;
   // A frame cut before its first full byte still counts against an armed reset
   wire logic any_frame = frame_end & ((byte_cnt != 2'h0) | pt_s2) & ~rst_busy;
   wire logic one_byte = exec & aligned & (byte_cnt == 2'h1);
   wire logic do_rst_en = one_byte & (opcode == flash_otp_pkg::OP_RST_EN);
   wire logic do_reset = one_byte & (opcode == flash_otp_pkg::OP_RST)
      & (state == flash_otp_pkg::ST_ARMED);
   wire logic do_enter = one_byte & (opcode == flash_otp_pkg::OP_OTP_MODE_ENTRY);
   wire logic do_exit = one_byte & (opcode == flash_otp_pkg::OP_OTP_MODE_EXIT);
   // No write-enable term; refused in secured mode or once locked
   wire logic do_lock_wr = exec & aligned & (byte_cnt == 2'h2)
      & (opcode == flash_otp_pkg::OP_LOCK_WR)
      & ~otp_mode & ~locked;
   wire logic stat_wr_op = (lnk.rx_byte == flash_otp_pkg::OP_STAT_WR1)
      | (lnk.rx_byte == flash_otp_pkg::OP_STAT_WR2);
   wire logic fwd = byte_ev & (byte_cnt == 2'h0) & ~rst_busy
      & ~flash_otp_pkg::is_local_op(lnk.rx_byte)
      & ~(otp_mode & stat_wr_op);

   // Byte position within the frame, saturating
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         byte_cnt <= 2'h0;
         opcode <= 8'h00;
         data <= 8'h00;
      end
      else
      begin
         if (cs_s2)
            byte_cnt <= 2'h0;
         else if (byte_ev && byte_cnt != 2'h3)
            byte_cnt <= byte_cnt + 2'h1;
         if (byte_ev && byte_cnt == 2'h0)
            opcode <= lnk.rx_byte;
         if (byte_ev && byte_cnt == 2'h1)
            data <= lnk.rx_byte;
      end
   end

   // ==========================================================
   // Reset sequencing
   reset_timer #(
      .CYCLES(RST_CYCLES)
   ) u_timer (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_start(do_reset),
      .o_busy(rst_busy)
   );

   // A repeated enable keeps the armed state; anything else disarms
   always_comb
   begin
      next_state = state;
      case (state)
         flash_otp_pkg::ST_NORMAL:
            if (do_rst_en)
               next_state = flash_otp_pkg::ST_ARMED;
         flash_otp_pkg::ST_ARMED:
            if (do_reset)
               next_state = flash_otp_pkg::ST_RESETTING;
            else if (any_frame && !do_rst_en)
               next_state = flash_otp_pkg::ST_NORMAL;
         flash_otp_pkg::ST_RESETTING:
            if (!rst_busy)
               next_state = flash_otp_pkg::ST_NORMAL;
         default:
            next_state = flash_otp_pkg::ST_NORMAL;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state <= flash_otp_pkg::ST_NORMAL;
      else
         state <= next_state;
   end

   // ==========================================================
   // Mode and lock bits
   // Lock cells are non-volatile: loaded once after release, not by reset
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         otp_mode <= 1'b0;
         fact_lock <= 1'b0;
         cust_lock <= 1'b0;
         locks_loaded <= 1'b0;
         o_cust_lock_prog <= 1'b0;
      end
      else
      begin
         if (do_reset)
            otp_mode <= 1'b0;
         else if (do_enter)
            otp_mode <= 1'b1;
         else if (do_exit)
            otp_mode <= 1'b0;
         locks_loaded <= 1'b1;
         if (!locks_loaded)
         begin
            fact_lock <= i_factory_lock;
            cust_lock <= i_cust_lock_nv;
         end
         else if (do_lock_wr && data[flash_otp_pkg::LOCK_CUSTOMER_BIT])
            cust_lock <= 1'b1;
         o_cust_lock_prog <= do_lock_wr & data[flash_otp_pkg::LOCK_CUSTOMER_BIT];
      end
   end

   assign lnk.lock_bits = {cust_lock, fact_lock};
   assign lnk.busy = rst_busy;

   // ==========================================================
   // Outputs toward the array engine
   // Registered so downstream sees clean levels
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_reset_abort <= 1'b0;
         o_busy <= 1'b0;
         o_otp_write_allow <= 1'b0;
         o_array_write_allow <= 1'b0;
         o_status_write_allow <= 1'b0;
         o_addr_in_otp <= 1'b0;
         o_addr_is_serial <= 1'b0;
         o_cmd_valid <= 1'b0;
         o_cmd_opcode <= 8'h00;
      end
      else
      begin
         o_reset_abort <= do_reset;
         o_busy <= i_array_busy | rst_busy;
         o_otp_write_allow <= otp_mode & ~locked & ~rst_busy;
         o_array_write_allow <= ~otp_mode & ~rst_busy;
         o_status_write_allow <= ~otp_mode & ~rst_busy;
         o_addr_in_otp <= otp_mode & (i_access_addr <= flash_otp_pkg::OTP_LAST);
         o_addr_is_serial <= otp_mode
            & (i_access_addr <= flash_otp_pkg::OTP_SERIAL_LAST);
         o_cmd_valid <= fwd;
         if (fwd)
            o_cmd_opcode <= lnk.rx_byte;
      end
   end

   assign o_otp_mode = otp_mode;
   assign o_reset_busy = rst_busy;

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   property p_reset_aborts;
      do_reset |=> o_reset_abort && rst_busy && !otp_mode;
   endproperty
   a_reset_aborts: assert property (p_reset_aborts) else $error("reset not taken");
   property p_cancel_enable;
      (state == flash_otp_pkg::ST_ARMED) && any_frame && !do_rst_en && !do_reset
         |=> state == flash_otp_pkg::ST_NORMAL;
   endproperty
   a_cancel_enable: assert property (p_cancel_enable) else $error("enable kept");
   property p_ignore_busy;
      rst_busy && frame_end |=> $stable(otp_mode) && $stable(cust_lock) && !o_cust_lock_prog;
   endproperty
   a_ignore_busy: assert property (p_ignore_busy) else $error("acted while busy");
   property p_enter;
      do_enter |=> otp_mode ##1 o_addr_in_otp || (i_access_addr > flash_otp_pkg::OTP_LAST);
   endproperty
   a_enter: assert property (p_enter) else $error("mode not entered");
   property p_exit;
      do_exit |=> !otp_mode;
   endproperty
   a_exit: assert property (p_exit) else $error("mode not left");
   property p_no_stat_wr;
      otp_mode |=> !o_status_write_allow && !o_cust_lock_prog;
   endproperty
   a_no_stat_wr: assert property (p_no_stat_wr) else $error("write in otp mode");
   property p_locked_read_only;
      locked && locks_loaded |=> !o_otp_write_allow;
   endproperty
   a_locked_read_only: assert property (p_locked_read_only) else $error("locked write");
   property p_lock_sticks;
      cust_lock && locks_loaded |=> cust_lock;
   endproperty
   a_lock_sticks: assert property (p_lock_sticks) else $error("lock cleared");
   property p_no_array_wr;
      otp_mode |=> !o_array_write_allow;
   endproperty
   a_no_array_wr: assert property (p_no_array_wr) else $error("array write");
   property p_aligned_lock_wr;
      o_cust_lock_prog |-> $past(aligned) && $past(byte_cnt) == 2'h2;
   endproperty
   a_aligned_lock_wr: assert property (p_aligned_lock_wr) else $error("bad frame");

   c_reset: cover property (do_reset ##1 rst_busy);
   c_enter: cover property (do_enter);
   c_lock_wr: cover property (o_cust_lock_prog);
endmodule : flash_reset_otp
`default_nettype wire

// ===== spi_host_model.sv
// Host controller model for the serial flash bus: owns sclk, cs_n, mosi.
// Assumes mode 0 timing and a device that drives miso on falling edges.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_mosi,
   input wire logic i_miso
);
   // ==========================================================
   // Bus timing
   localparam int HALF_NS = 80;
   localparam int SKEW_NS = 3;

   // Idle bus: clock parked low, chip select high
   initial
   begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end

   // ==========================================================
   // One frame; nbits low bits of data go out MSB first, miso gathered
   // Skew offsets sclk edges 3 ns from the call; back-to-back frames can still land them on core clock edges
   task automatic xfer(input logic [23:0] data, input int nbits, output logic [23:0] rdata);
      int i;
      rdata = 24'h000000;
      #(SKEW_NS);
      o_cs_n = 1'b0;
      for (i = nbits - 1; i >= 0; i--)
      begin
         o_mosi = data[i];
         #(HALF_NS);
         o_sclk = 1'b1;
         rdata = {rdata[22:0], i_miso};
         #(HALF_NS);
         o_sclk = 1'b0;
      end
      #(HALF_NS);
      o_cs_n = 1'b1;
      o_mosi = ~o_mosi; // Stale data never left looking valid
      #(4 * HALF_NS);
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the reset and secured-OTP command block.
// Assumes the host model above; reset interval shortened by parameter.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int RST_N_CYC = 400;
   logic i_mclk, i_rst_n, i_sclk, i_cs_n, i_mosi, o_miso, o_miso_oe;
   logic i_factory_lock, i_cust_lock_nv, i_array_busy;
   logic [23:0] i_access_addr;
   logic o_addr_in_otp, o_addr_is_serial, o_otp_mode, o_reset_abort, o_reset_busy, o_busy;
   logic o_cust_lock_prog, o_otp_write_allow, o_array_write_allow, o_status_write_allow;
   logic o_cmd_valid;
   logic [7:0] o_cmd_opcode, last_op, b;
   logic [23:0] rd;
   logic [31:0] seed;
   int mismatches = 0, n_checks = 0, n_prog = 0, n_cmd = 0, n_abort = 0, busy_len = 0;
   int p0, c0, a0, k;

   flash_reset_otp #(.RST_CYCLES(RST_N_CYC)) uut (.i_mclk, .i_rst_n, .i_sclk, .i_cs_n,
      .i_mosi, .o_miso, .o_miso_oe, .i_factory_lock, .i_cust_lock_nv, .i_array_busy,
      .i_access_addr, .o_addr_in_otp, .o_addr_is_serial, .o_otp_mode, .o_reset_abort,
      .o_reset_busy, .o_busy, .o_cust_lock_prog, .o_otp_write_allow, .o_array_write_allow,
      .o_status_write_allow, .o_cmd_valid, .o_cmd_opcode);
   // Released data line floats to its pull-up, so a missing enable reads as ones
   spi_host_model m (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_mosi(i_mosi),
      .i_miso(o_miso_oe ? o_miso : 1'b1));

   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // ==========================================================
   // Pulse monitor; counts deltas so checks never depend on race order
   always @(posedge i_mclk)
   begin
      if (o_cust_lock_prog === 1'b1) n_prog++;
      if (o_cmd_valid === 1'b1)
      begin
         n_cmd++;
         last_op = o_cmd_opcode;
      end
      if (o_reset_abort === 1'b1) busy_len = 0;
      if (o_reset_abort === 1'b1) n_abort++;
      if (o_reset_busy === 1'b1) busy_len++;
   end

   // ==========================================================
   // Expectation and stimulus helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction : xs

   function automatic logic [7:0] lock_exp(input logic c, input logic f);
      lock_exp = {flash_otp_pkg::LOCK_RSVD_VALUE, c, f};
   endfunction : lock_exp

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic mode_is(input logic [3:0] exp);
      chk({12'h000, o_otp_mode, o_array_write_allow, o_status_write_allow, o_otp_write_allow},
         {12'h000, exp}, "mode flags");
   endtask : mode_is

   task automatic op(input logic [7:0] code);
      m.xfer({16'h0000, code}, 8, rd);
   endtask : op

   // Two copies of the byte show it repeats while clocking goes on
   task automatic lock_rd(input logic c, input logic f);
      m.xfer({8'h2B, 16'h0000}, 24, rd);
      chk({8'h00, rd[15:8]}, {8'h00, lock_exp(c, f)}, "lock byte");
      chk({8'h00, rd[7:0]}, {8'h00, lock_exp(c, f)}, "lock repeat");
   endtask : lock_rd

   task automatic addr_at(input logic [23:0] a, input logic otp);
      @(posedge i_mclk);
      #1 i_access_addr = a;
      repeat (2) @(posedge i_mclk);
      #1 chk({14'h0000, o_addr_in_otp, o_addr_is_serial}, {14'h0000,
         otp && (a <= flash_otp_pkg::OTP_LAST), otp && (a <= flash_otp_pkg::OTP_SERIAL_LAST)},
         "region map");
   endtask : addr_at

   // Lock cells held steady across release, as they are sampled then
   task automatic hw_reset(input logic f, input logic c);
      @(posedge i_mclk);
      #1 i_rst_n = 1'b0;
      i_factory_lock = f;
      i_cust_lock_nv = c;
      repeat (16) @(posedge i_mclk);
      #1 i_rst_n = 1'b1;
      repeat (5) @(posedge i_mclk);
   endtask : hw_reset

   // ==========================================================
   // Main sequence
   initial
   begin
      i_rst_n = 1'b0;
      i_factory_lock = 1'b0;
      i_cust_lock_nv = 1'b0;
      i_array_busy = 1'b0;
      i_access_addr = 24'h000000;
      seed = 32'h578B4FB9;
      hw_reset(1'b0, 1'b0);
      mode_is(4'b0110);
      lock_rd(1'b0, 1'b0);
      // Array busy shows on busy; lock byte still answers meanwhile
      @(posedge i_mclk);
      #1 i_array_busy = 1'b1;
      repeat (2) @(posedge i_mclk);
      #1 chk({15'h0000, o_busy}, 16'h0001, "array busy");
      lock_rd(1'b0, 1'b0);
      @(posedge i_mclk);
      #1 i_array_busy = 1'b0;
      // Secured mode redirects and bars array, status and lock writes
      op(8'hB1);
      mode_is(4'b1001);
      addr_at(24'h000000, 1'b1);
      addr_at(24'h00000F, 1'b1);
      addr_at(24'h000010, 1'b1);
      addr_at(24'h0001FF, 1'b1);
      addr_at(24'h000200, 1'b1);
      for (k = 0; k < 3; k++)
      begin
         seed = xs(seed);
         addr_at({15'h0000, seed[8:0]} | (seed[31] ? {seed[23:9], 9'h000} : 24'h0), 1'b1);
      end
      p0 = n_prog;
      c0 = n_cmd;
      m.xfer({8'h2F, 8'h02}, 16, rd);
      op(8'h01);
      op(8'h31);
      chk(16'(n_prog - p0), 16'h0000, "lock write in otp");
      chk(16'(n_cmd - c0), 16'h0000, "status write in otp");
      lock_rd(1'b0, 1'b0);
      op(8'hC1);
      mode_is(4'b0110);
      addr_at(24'h000005, 1'b0);
      // Lock write cut mid-byte, then a proper one with no write enable
      m.xfer({9'h000, 8'h2F, 7'h01}, 15, rd);
      chk(16'(n_prog - p0), 16'h0000, "ragged lock write");
      lock_rd(1'b0, 1'b0);
      m.xfer({8'h2F, 8'h02}, 16, rd);
      chk(16'(n_prog - p0), 16'h0001, "lock write");
      lock_rd(1'b1, 1'b0);
      op(8'hB1);
      mode_is(4'b1000);
      op(8'hC1);
      m.xfer({8'h2F, 8'h02}, 16, rd);
      chk(16'(n_prog - p0), 16'h0001, "relock");
      // Enable then something else cancels the pair
      a0 = n_abort;
      for (k = 0; k < 3; k++)
      begin
         seed = xs(seed);
         b = seed[7:0];
         if (b == 8'h66 || b == 8'h99 || b == 8'hB1 || b == 8'hC1 || b == 8'h2B || b == 8'h2F)
            b = b ^ 8'h01;
         c0 = n_cmd;
         op(8'h66);
         op(b);
         op(8'h99);
         chk(16'(n_cmd - c0), 16'h0001, "forward");
         chk({8'h00, last_op}, {8'h00, b}, "forward code");
      end
      op(8'h66);
      m.xfer(24'h000006, 4, rd);
      op(8'h99);
      chk(16'(n_abort - a0), 16'h0000, "cancelled reset");
      // Accepted reset from secured mode, host checked busy was clear first
      op(8'hB1);
      chk({15'h0000, o_busy}, 16'h0000, "idle before reset");
      op(8'h66);
      op(8'h99);
      chk(16'(n_abort - a0), 16'h0001, "abort pulse");
      chk({14'h0000, o_reset_busy, o_busy}, 16'h0003, "reset busy");
      mode_is(4'b0000);
      op(8'hB1);
      chk({15'h0000, o_otp_mode}, 16'h0000, "ignored in reset");
      for (k = 0; k < RST_N_CYC + 50 && o_reset_busy !== 1'b0; k++) @(posedge i_mclk);
      if (k >= RST_N_CYC + 50)
      begin
         mismatches++;
         test_done();
      end
      chk(16'(busy_len), 16'(RST_N_CYC), "reset length");
      #1 mode_is(4'b0110);
      lock_rd(1'b1, 1'b0);
      // Factory-locked part: flag reads back, region and lock frozen
      hw_reset(1'b1, 1'b0);
      lock_rd(1'b0, 1'b1);
      p0 = n_prog;
      m.xfer({8'h2F, 8'h02}, 16, rd);
      chk(16'(n_prog - p0), 16'h0000, "factory locked");
      op(8'hB1);
      mode_is(4'b1000);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
